/* File: verilog/pat_regs.sv */
// register bank: mode bits, memory test, test queue, thresholds, id rom
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/100ps
`include "pat_defs.svh"
module pat_regs
    import pat_pkg::*;
#(
    parameter int  NUM_CH    = 8,
    parameter int  QDEPTH    = 16,
    parameter logic [7:0] ID_OUI_U = 8'h11, // arbitrary value
    parameter logic [7:0] ID_OUI_M = 8'h22, // arbitrary value
    parameter logic [7:0] ID_OUI_L = 8'h33, // arbitrary value
    parameter logic [7:0] ID_VER   = 8'h44, // arbitrary value
    parameter logic [7:0] ID_BRD_U = 8'h55, // arbitrary value
    parameter logic [7:0] ID_BRD_M = 8'h66, // arbitrary value
    parameter logic [7:0] ID_BRD_L = 8'h77, // arbitrary value
    parameter logic [7:0] ID_REV   = 8'h88, // arbitrary value
    parameter logic [7:0] ID_SER_U = 8'h99, // arbitrary value
    parameter logic [7:0] ID_SER_L = 8'hAA  // arbitrary value
) (
    // clock and resets
    input  wire logic           i_clk,
    input  wire logic           i_reset,
    input  wire logic           i_data_reset,
    // register access
    input  wire pat_bus_type    i_bus,
    output logic [15:0]         o_rdata,
    // converter side
    input  wire logic [11:0]    i_raw_a,
    input  wire logic [11:0]    i_raw_b,
    input  wire logic           i_raw_valid,
    input  wire logic [3:0]     i_ch_sel,
    input  wire logic [11:0]    i_ch_value,
    input  wire logic           i_tq_pop,
    // controls to acquisition logic
    output logic [15:0]         o_mode,
    output logic [7:0]          o_crate,
    output logic [7:0]          o_slide_dac,
    output logic                o_evc_clear,
    output logic                o_sw_convert,
    output pat_mem_wr_type      o_mem_wr,
    output logic                o_ch_keep,
    output logic                o_ch_above,
    output logic                o_tq_active,
    output logic [12:0]         o_tq_word
);
    localparam int NTHR = 2 * NUM_CH;
    localparam int QW   = $clog2(QDEPTH);
    initial begin
        if (NUM_CH != 8 || QDEPTH != 16) begin
            $error("pat_regs: only 8 channels and a 16-word queue");
        end
    end

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    logic wr_set, wr_clr, wr_wa, wr_hi, wr_lo, wr_cr;
    logic wr_tev, wr_evc, wr_ra, wr_sw, wr_sl, wr_thr;
    logic [3:0] thr_idx;
    assign wr_set = i_bus.wr && i_bus.addr == `PAT_OFS_MODE_SET;
    assign wr_clr = i_bus.wr && i_bus.addr == `PAT_OFS_MODE_CLR;
    assign wr_wa  = i_bus.wr && i_bus.addr == `PAT_OFS_MT_WADDR;
    assign wr_hi  = i_bus.wr && i_bus.addr == `PAT_OFS_MT_HI;
    assign wr_lo  = i_bus.wr && i_bus.addr == `PAT_OFS_MT_LO;
    assign wr_cr  = i_bus.wr && i_bus.addr == `PAT_OFS_CRATE;
    assign wr_tev = i_bus.wr && i_bus.addr == `PAT_OFS_TEV_WR;
    assign wr_evc = i_bus.wr && i_bus.addr == `PAT_OFS_EVC_CLR;
    assign wr_ra  = i_bus.wr && i_bus.addr == `PAT_OFS_MT_RADDR;
    assign wr_sw  = i_bus.wr && i_bus.addr == `PAT_OFS_SW_TRIG;
    assign wr_sl  = i_bus.wr && i_bus.addr == `PAT_OFS_SLIDE;
    // threshold entries every fourth byte from the base
    assign thr_idx = i_bus.addr[5:2];
    assign wr_thr  = i_bus.wr && i_bus.addr >= `PAT_OFS_THR_BASE
                     && i_bus.addr <= `PAT_OFS_THR_LAST
                     && i_bus.addr[1:0] == 2'b10 - 2'b10;

    // -----------------------------------------------------------------
    // mode register
    // -----------------------------------------------------------------
    logic [15:0] mode_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_reg <= `PAT_MODE_RESET;
        end else if (wr_set) begin
            mode_reg <= mode_reg | i_bus.data;
        end else if (wr_clr) begin
            mode_reg <= mode_reg & ~i_bus.data;
        end
    end
    assign o_mode = mode_reg;

    // -----------------------------------------------------------------
    // direct memory test
    // -----------------------------------------------------------------
    logic [10:0] wa_reg, ra_reg;
    logic [15:0] hi_reg;
    pat_mem_wr_type mem_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wa_reg <= 11'h000;
            ra_reg <= 11'h000;
            hi_reg <= 16'h0000;
        end else begin
            if (wr_wa) begin
                wa_reg <= i_bus.data[10:0];
            end
            if (wr_ra) begin
                ra_reg <= i_bus.data[10:0];
            end
            if (wr_hi) begin
                hi_reg <= i_bus.data;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mem_reg <= '0;
        end else begin
            mem_reg.we <= wr_lo;
            if (wr_lo) begin
                mem_reg.addr <= wa_reg;
                mem_reg.data <= {hi_reg, i_bus.data};
            end
        end
    end
    assign o_mem_wr = mem_reg;

    // -----------------------------------------------------------------
    // crate, slide constant, strobes
    // -----------------------------------------------------------------
    logic [7:0] crate_reg, slide_reg;
    logic       evc_reg, sw_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            crate_reg <= 8'h00;
            slide_reg <= 8'h00;
        end else begin
            if (wr_cr) begin
                crate_reg <= i_bus.data[7:0];
            end
            if (wr_sl) begin
                slide_reg <= i_bus.data[7:0];
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            evc_reg <= 1'b0;
            sw_reg  <= 1'b0;
        end else begin
            evc_reg <= wr_evc;
            sw_reg  <= wr_sw;
        end
    end
    assign o_crate      = crate_reg;
    assign o_evc_clear  = evc_reg;
    assign o_sw_convert = sw_reg;
    assign o_slide_dac  = mode_reg[`PAT_MODE_SLDEN] ? 8'h00
                                                    : slide_reg;

    // -----------------------------------------------------------------
    // acquisition test queue
    // -----------------------------------------------------------------
    logic [12:0]   tq_mem [QDEPTH];
    logic [QW-1:0] tq_wp_reg, tq_rp_reg;
    logic          acq_d_reg;
    logic          acq_rise, acq_fall;
    assign acq_rise = mode_reg[`PAT_MODE_ACQTEST] && !acq_d_reg;
    assign acq_fall = !mode_reg[`PAT_MODE_ACQTEST] && acq_d_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            acq_d_reg <= 1'b0;
        end else begin
            acq_d_reg <= mode_reg[`PAT_MODE_ACQTEST];
        end
    end
    always_ff @(posedge i_clk) begin
        if (wr_tev) begin
            tq_mem[tq_wp_reg] <= i_bus.data[12:0];
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reset || acq_rise) begin
            tq_wp_reg <= '0;
        end else if (wr_tev) begin
            tq_wp_reg <= tq_wp_reg + 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reset || acq_fall) begin
            tq_rp_reg <= '0;
        end else if (i_tq_pop && mode_reg[`PAT_MODE_ACQTEST]) begin
            tq_rp_reg <= tq_rp_reg + 1'b1;
        end
    end
    assign o_tq_active = mode_reg[`PAT_MODE_ACQTEST];
    logic [12:0] tq_word_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tq_word_reg <= 13'h0000;
        end else begin
            tq_word_reg <= tq_mem[tq_rp_reg];
        end
    end
    assign o_tq_word = tq_word_reg;

    // -----------------------------------------------------------------
    // thresholds and raw values
    // -----------------------------------------------------------------
    logic [8:0]  thr_reg [NTHR];
    logic [11:0] raw_a_reg, raw_b_reg;
    genvar g;
    generate
        for (g = 0; g < NTHR; g++) begin : g_thr
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    thr_reg[g] <= 9'h000;
                end else if (wr_thr && thr_idx == 4'(g)) begin
                    thr_reg[g] <= i_bus.data[8:0];
                end
            end
        end
    endgenerate
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            raw_a_reg <= 12'h000;
            raw_b_reg <= 12'h000;
        end else if (i_raw_valid) begin
            raw_a_reg <= i_raw_a;
            raw_b_reg <= i_raw_b;
        end
    end
    logic keep_reg, above_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            keep_reg  <= 1'b0;
            above_reg <= 1'b0;
        end else begin
            keep_reg  <= !thr_reg[i_ch_sel][`PAT_THR_KILL];
            above_reg <= i_ch_value[11:4]
                         >= thr_reg[i_ch_sel][7:0];
        end
    end
    assign o_ch_keep  = keep_reg;
    assign o_ch_above = above_reg;

    // -----------------------------------------------------------------
    // read mux
    // -----------------------------------------------------------------
    logic [15:0] rdata_next, rdata_reg;
    always_comb begin
        rdata_next = 16'h0000;
        if (i_bus.addr >= `PAT_OFS_THR_BASE
            && i_bus.addr <= `PAT_OFS_THR_LAST
            && i_bus.addr[1:0] == 2'b00) begin
            rdata_next = {7'h00, thr_reg[thr_idx]};
        end else begin
            case (i_bus.addr)
                `PAT_OFS_MODE_SET:  rdata_next = mode_reg;
                `PAT_OFS_CRATE:     rdata_next = {8'h00, crate_reg};
                `PAT_OFS_SLIDE:     rdata_next = {8'h00, slide_reg};
                `PAT_OFS_RAW_A:     rdata_next = {4'h0, raw_a_reg};
                `PAT_OFS_RAW_B:     rdata_next = {4'h0, raw_b_reg};
                `PAT_OFS_ROM_OUI_U: rdata_next = {8'h00, ID_OUI_U};
                `PAT_OFS_ROM_OUI_M: rdata_next = {8'h00, ID_OUI_M};
                `PAT_OFS_ROM_OUI_L: rdata_next = {8'h00, ID_OUI_L};
                `PAT_OFS_ROM_VER:   rdata_next = {8'h00, ID_VER};
                `PAT_OFS_ROM_BRD_U: rdata_next = {8'h00, ID_BRD_U};
                `PAT_OFS_ROM_BRD_M: rdata_next = {8'h00, ID_BRD_M};
                `PAT_OFS_ROM_BRD_L: rdata_next = {8'h00, ID_BRD_L};
                `PAT_OFS_ROM_REV:   rdata_next = {8'h00, ID_REV};
                `PAT_OFS_ROM_SER_U: rdata_next = {8'h00, ID_SER_U};
                `PAT_OFS_ROM_SER_L: rdata_next = {8'h00, ID_SER_L};
                default:            rdata_next = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_reg <= 16'h0000;
        end else if (i_bus.rd) begin
            rdata_reg <= rdata_next;
        end
    end
    assign o_rdata = rdata_reg;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_mode_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_clr |=> (mode_reg & $past(i_bus.data)) == 16'h0000)
        else $error("mode clear left a bit set");
    a_mode_set: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_set |=> (mode_reg & $past(i_bus.data)) == $past(i_bus.data))
        else $error("mode set missed a bit");
    a_mem_push: assert property (@(posedge i_clk) disable iff (i_reset)
        o_mem_wr.we |-> $past(wr_lo))
        else $error("memory write without low half");
    a_mem_data: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_lo |=> o_mem_wr.data[31:16] == $past(hi_reg)
                  && o_mem_wr.addr == $past(wa_reg))
        else $error("memory pattern wrong");
    a_evc_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_evc |=> o_evc_clear ##1 !o_evc_clear || $past(wr_evc))
        else $error("counter clear strobe wrong");
    a_sw_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
        o_sw_convert == $past(wr_sw))
        else $error("trigger strobe wrong");
    a_slide_out: assert property (@(posedge i_clk) disable iff (i_reset)
        !mode_reg[`PAT_MODE_SLDEN] |-> o_slide_dac == slide_reg)
        else $error("slide constant not driven");
    a_queue_wptr: assert property (@(posedge i_clk) disable iff (i_reset)
        acq_rise |=> tq_wp_reg == '0)
        else $error("write pointer not reset");
    a_queue_adv: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_tev && !acq_rise |=> tq_wp_reg == $past(tq_wp_reg) + 1'b1)
        else $error("queue pointer did not advance");
    a_queue_rptr: assert property (@(posedge i_clk) disable iff (i_reset)
        acq_fall |=> tq_rp_reg == '0)
        else $error("read pointer not reset");
    a_queue_pop: assert property (@(posedge i_clk) disable iff (i_reset)
        i_tq_pop && mode_reg[`PAT_MODE_ACQTEST] && !acq_fall
        |=> tq_rp_reg == $past(tq_rp_reg) + 1'b1)
        else $error("read pointer did not advance");
    a_queue_word: assert property (@(posedge i_clk) disable iff (i_reset)
        !$past(i_reset) |-> o_tq_word == $past(tq_mem[tq_rp_reg]))
        else $error("queue word not presented");
    a_crate_load: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_cr |=> o_crate == $past(i_bus.data[7:0]))
        else $error("crate identifier not loaded");
    a_waddr_load: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_wa |=> wa_reg == $past(i_bus.data[10:0]))
        else $error("test write address not loaded");
    a_raw_load: assert property (@(posedge i_clk) disable iff (i_reset)
        i_raw_valid |=> raw_a_reg == $past(i_raw_a)
                        && raw_b_reg == $past(i_raw_b))
        else $error("raw values not captured");
    a_keep_flag: assert property (@(posedge i_clk) disable iff (i_reset)
        !$past(i_reset)
        |-> o_ch_keep == !$past(thr_reg[i_ch_sel][`PAT_THR_KILL]))
        else $error("kill bit not applied");
    a_above_flag: assert property (@(posedge i_clk) disable iff (i_reset)
        !$past(i_reset)
        |-> o_ch_above == ($past(i_ch_value[11:4])
                           >= $past(thr_reg[i_ch_sel][7:0])))
        else $error("threshold compare wrong");
    a_rdata_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_bus.rd |=> $stable(o_rdata))
        else $error("read data changed without a read");
endmodule // pat_regs

/* File: pkg/pat_defs.svh */
// register offsets, field positions and widths of the test and threshold bank
`ifndef PAT_DEFS_SVH
`define PAT_DEFS_SVH
`define PAT_ADDR_W          16
`define PAT_OFS_MODE_SET    16'h1032
`define PAT_OFS_MODE_CLR    16'h1034
`define PAT_OFS_MT_WADDR    16'h1036
`define PAT_OFS_MT_HI       16'h1038
`define PAT_OFS_MT_LO       16'h103A
`define PAT_OFS_CRATE       16'h103C
`define PAT_OFS_TEV_WR      16'h103E
`define PAT_OFS_EVC_CLR     16'h1040
`define PAT_OFS_MT_RADDR    16'h1064
`define PAT_OFS_SW_TRIG     16'h1068
`define PAT_OFS_SLIDE       16'h106A
`define PAT_OFS_RAW_A       16'h1070
`define PAT_OFS_RAW_B       16'h1072
`define PAT_OFS_THR_BASE    16'h1080
`define PAT_OFS_THR_LAST    16'h10BE
`define PAT_OFS_ROM_OUI_U   16'h8026
`define PAT_OFS_ROM_OUI_M   16'h802A
`define PAT_OFS_ROM_OUI_L   16'h802E
`define PAT_OFS_ROM_VER     16'h8032
`define PAT_OFS_ROM_BRD_U   16'h8036
`define PAT_OFS_ROM_BRD_M   16'h803A
`define PAT_OFS_ROM_BRD_L   16'h803E
`define PAT_OFS_ROM_REV     16'h804E
`define PAT_OFS_ROM_SER_U   16'h8F02
`define PAT_OFS_ROM_SER_L   16'h8F06
`define PAT_MODE_MEMTEST    0
`define PAT_MODE_ACQTEST    6
`define PAT_MODE_SLDEN      7
`define PAT_MODE_RESET      16'h0000
`define PAT_THR_KILL        8
`define PAT_TEV_OV          12
`define PAT_THR_RESET       16'h0000
`endif

/* File: pkg/pat_pkg.sv */
// shared types of the test and threshold bank
package pat_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] data;
    } pat_bus_type;
    typedef struct packed {
        logic        we;
        logic [10:0] addr;
        logic [31:0] data;
    } pat_mem_wr_type;
endpackage

/* File: verif/pat_host.sv */
// bus master model that issues register writes and reads
`timescale 1ns/100ps
module pat_host
    import pat_pkg::*;
(
    // clock
    input  wire logic        i_clk,
    // register access
    output pat_bus_type      o_bus,
    input  wire logic [15:0] i_rdata
);
    initial begin
        o_bus = '0;
    end

    // one write: request held for one edge, then released
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge i_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    // one read: data taken after the edge that samples the request
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'hA5A5};
        @(posedge i_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 16'h5A5A};
        #1;
        d = i_rdata;
    endtask
endmodule // pat_host

/* File: verif/tb_top.sv */
// self-checking bench of the test and threshold register bank
`timescale 1ns/100ps
`include "pat_defs.svh"
module tb_top
    import pat_pkg::*;
;
    localparam logic [15:0] ROM_A [10] = '{`PAT_OFS_ROM_OUI_U,
        `PAT_OFS_ROM_OUI_M, `PAT_OFS_ROM_OUI_L, `PAT_OFS_ROM_VER,
        `PAT_OFS_ROM_BRD_U, `PAT_OFS_ROM_BRD_M, `PAT_OFS_ROM_BRD_L,
        `PAT_OFS_ROM_REV, `PAT_OFS_ROM_SER_U, `PAT_OFS_ROM_SER_L};
    // arbitrary identification values
    localparam logic [7:0] ROM_V [10] = '{8'hC1, 8'hC2, 8'hC3, 8'hC4,
        8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hCA};
    logic           i_clk = 1'b0;
    logic           i_reset = 1'b1;
    logic           data_rst = 1'b0;
    logic           raw_valid = 1'b0;
    logic           tq_pop = 1'b0;
    logic [11:0]    raw_a = 12'h000;
    logic [11:0]    raw_b = 12'h000;
    logic [11:0]    ch_value = 12'h000;
    logic [3:0]     ch_sel = 4'h0;
    pat_bus_type    bus;
    logic [15:0]    rdata;
    logic [15:0]    mode;
    logic [7:0]     crate;
    logic [7:0]     slide;
    logic           evc;
    logic           swc;
    logic           keep;
    logic           above;
    logic           tqa;
    logic [12:0]    tqw;
    pat_mem_wr_type memw;
    pat_mem_wr_type mem_last;
    logic [15:0]    r;
    int             error_cnt = 0;
    int             compares = 0;
    int             cyc = 0;
    int             n_mem = 0;
    int             n_evc = 0;
    int             n_sw = 0;

    pat_host i_pat_host (.i_clk(i_clk), .o_bus(bus), .i_rdata(rdata));

    pat_regs #(
        .ID_OUI_U(ROM_V[0]), .ID_OUI_M(ROM_V[1]), .ID_OUI_L(ROM_V[2]),
        .ID_VER(ROM_V[3]), .ID_BRD_U(ROM_V[4]), .ID_BRD_M(ROM_V[5]),
        .ID_BRD_L(ROM_V[6]), .ID_REV(ROM_V[7]), .ID_SER_U(ROM_V[8]),
        .ID_SER_L(ROM_V[9])
    ) i_pat_regs (
        .i_clk(i_clk), .i_reset(i_reset), .i_data_reset(data_rst),
        .i_bus(bus), .o_rdata(rdata), .i_raw_a(raw_a), .i_raw_b(raw_b),
        .i_raw_valid(raw_valid), .i_ch_sel(ch_sel), .i_ch_value(ch_value),
        .i_tq_pop(tq_pop), .o_mode(mode), .o_crate(crate),
        .o_slide_dac(slide), .o_evc_clear(evc), .o_sw_convert(swc),
        .o_mem_wr(memw), .o_ch_keep(keep), .o_ch_above(above),
        .o_tq_active(tqa), .o_tq_word(tqw)
    );

    always #10 i_clk = ~i_clk;

    // count the one-cycle pulses coming out of the bank
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (memw.we === 1'b1) begin
            n_mem <= n_mem + 1;
            mem_last <= memw;
        end
        if (evc === 1'b1) n_evc <= n_evc + 1;
        if (swc === 1'b1) n_sw <= n_sw + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    task automatic end_of_test();
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_mode();
        i_pat_host.wr(`PAT_OFS_MODE_SET, 16'h00C5);
        i_pat_host.wr(`PAT_OFS_MODE_SET, 16'h0002);
        i_pat_host.rd(`PAT_OFS_MODE_SET, r);
        chk(r, 16'h00C7, "mode set");
        i_pat_host.wr(`PAT_OFS_MODE_CLR, 16'h0004);
        i_pat_host.rd(`PAT_OFS_MODE_SET, r);
        chk(r, 16'h00C3, "mode clear");
        i_pat_host.wr(`PAT_OFS_MODE_CLR, 16'h00C3);
        settle();
        chk(mode, 16'h0000, "mode port");
        i_pat_host.rd(`PAT_OFS_MODE_CLR, r);
        chk(r, 16'h0000, "clear loc read");
    endtask

    task automatic t_memtest();
        i_pat_host.wr(`PAT_OFS_MODE_SET, 16'h0001);
        i_pat_host.wr(`PAT_OFS_MT_RADDR, 16'h0000);
        i_pat_host.wr(`PAT_OFS_MT_WADDR, 16'hFFFF);
        i_pat_host.wr(`PAT_OFS_MT_HI, 16'hABCD);
        settle();
        chk(16'(n_mem), 16'h0000, "upper pushes");
        i_pat_host.wr(`PAT_OFS_MT_LO, 16'h1234);
        settle();
        chk(16'(n_mem), 16'h0001, "lower push");
        chk(16'(mem_last.addr), 16'h07FF, "mem addr");
        chk(mem_last.data[31:16], 16'hABCD, "mem upper");
        chk(mem_last.data[15:0], 16'h1234, "mem lower");
        i_pat_host.wr(`PAT_OFS_MT_LO, 16'h5678);
        settle();
        chk(16'(n_mem), 16'h0002, "second push");
        chk(mem_last.data[31:16], 16'hABCD, "upper kept");
        i_pat_host.rd(`PAT_OFS_MT_WADDR, r);
        chk(r, 16'h0000, "wo read");
        i_pat_host.wr(`PAT_OFS_MODE_CLR, 16'h0001);
    endtask

    task automatic t_misc();
        i_pat_host.wr(`PAT_OFS_CRATE, 16'h12AB);
        i_pat_host.rd(`PAT_OFS_CRATE, r);
        chk(r, 16'h00AB, "crate read");
        chk(16'(crate), 16'h00AB, "crate port");
        i_pat_host.wr(`PAT_OFS_EVC_CLR, 16'h0000);
        i_pat_host.wr(`PAT_OFS_EVC_CLR, 16'hFFFF);
        i_pat_host.wr(`PAT_OFS_SW_TRIG, 16'h0000);
        settle();
        chk(16'(n_evc), 16'h0002, "evc pulses");
        chk(16'(n_sw), 16'h0001, "trigger pulses");
        i_pat_host.rd(`PAT_OFS_SW_TRIG, r);
        chk(r, 16'h0000, "strobe read");
        i_pat_host.wr(`PAT_OFS_SLIDE, 16'h005A);
        i_pat_host.rd(`PAT_OFS_SLIDE, r);
        chk(r, 16'h005A, "slide read");
        chk(16'(slide), 16'h005A, "slide dac");
        i_pat_host.wr(`PAT_OFS_MODE_SET, 16'h0080);
        settle();
        chk(16'(slide), 16'h0000, "slide enabled");
        i_pat_host.wr(`PAT_OFS_MODE_CLR, 16'h0080);
        @(posedge i_clk);
        raw_a <= 12'hABC;
        raw_b <= 12'h123;
        raw_valid <= 1'b1;
        @(posedge i_clk);
        raw_valid <= 1'b0;
        raw_a <= 12'h000;
        i_pat_host.wr(`PAT_OFS_RAW_A, 16'hFFFF);
        i_pat_host.rd(`PAT_OFS_RAW_A, r);
        chk(r, 16'h0ABC, "raw a");
        i_pat_host.rd(`PAT_OFS_RAW_B, r);
        chk(r, 16'h0123, "raw b");
    endtask

    task automatic t_thr();
        logic [7:0] t;
        for (int i = 0; i < 16; i++)
            i_pat_host.wr(16'(`PAT_OFS_THR_BASE + 4 * i),
                          {7'h00, i[0], 8'(i * 16 + 8)});
        @(posedge i_clk);
        data_rst <= 1'b1;
        @(posedge i_clk);
        data_rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            t = 8'(i * 16 + 8);
            i_pat_host.rd(16'(`PAT_OFS_THR_BASE + 4 * i), r);
            chk(r, {7'h00, i[0], t}, "thr read");
            for (int k = 0; k < 2; k++) begin
                @(posedge i_clk);
                ch_sel <= 4'(i);
                ch_value <= {t - 8'(1 - k), 4'hF};
                repeat (2) @(posedge i_clk);
                #1;
                chk(16'(keep), 16'(!i[0]), "keep");
                chk(16'(above), 16'(k), "above");
            end
        end
    endtask

    task automatic t_rom();
        for (int k = 0; k < 10; k++) begin
            i_pat_host.wr(ROM_A[k], 16'h0000);
            i_pat_host.rd(ROM_A[k], r);
            chk(r, {8'h00, ROM_V[k]}, "id byte");
        end
        i_pat_host.rd(16'h1000, r);
        chk(r, 16'h0000, "unmapped read");
    endtask

    task automatic t_queue();
        i_pat_host.wr(`PAT_OFS_MODE_SET, 16'h0040);
        i_pat_host.wr(`PAT_OFS_MODE_CLR, 16'h0040);
        for (int k = 0; k < 16; k++)
            i_pat_host.wr(`PAT_OFS_TEV_WR,
                          {3'h0, k[0], 12'(k * 273)});
        i_pat_host.wr(`PAT_OFS_MODE_SET, 16'h0040);
        settle();
        chk(16'(tqa), 16'h0001, "test active");
        for (int k = 0; k < 16; k++) begin
            chk(16'(tqw), {3'h0, k[0], 12'(k * 273)},
                "queue word");
            @(posedge i_clk);
            tq_pop <= 1'b1;
            @(posedge i_clk);
            tq_pop <= 1'b0;
            repeat (2) @(posedge i_clk);
            #1;
        end
        i_pat_host.wr(`PAT_OFS_MODE_CLR, 16'h0040);
        settle();
        chk(16'(tqa), 16'h0000, "test inactive");
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        #1;
        chk(mode, 16'h0000, "mode after reset");
        t_mode();
        t_memtest();
        t_misc();
        t_thr();
        t_rom();
        t_queue();
        end_of_test();
    end
endmodule // tb_top
